// *** src/pmt_regs.svh ***
// Register indices, field positions and reset values of the modulo timer
`ifndef PMT_REGS_SVH
`define PMT_REGS_SVH

`define PMT_IDX_CTRL 8'h4B
`define PMT_IDX_CNTH 8'h4C
`define PMT_IDX_CNTL 8'h4D
`define PMT_IDX_MODH 8'h4E
`define PMT_IDX_MODL 8'h4F
`define PMT_IDX_EVT_STATUS 8'h50
`define PMT_IDX_EVT_CLEAR 8'h51
`define PMT_IDX_EVT_ENABLE 8'h52
`define PMT_IDX_NONE 8'h00

`define PMT_BIT_FLAG 7
`define PMT_BIT_IRQ_EN 6
`define PMT_BIT_HALT 5
`define PMT_BIT_CRST 4
`define PMT_PS_MSB 2
`define PMT_EVT_ROLL 0

`define PMT_MOD_RST 16'hFFFF
`define PMT_HALT_RST 1'b1
`define PMT_IRQ_EN_RST 1'b0
`define PMT_PS_RST 3'h0
`define PMT_PS_MAX 3'h6

`endif

// *** src/pmt_pkg.sv ***
// Shared types of the modulo timer
package pmt_pkg;

    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] idx;
    } pmt_aphase_t;

    typedef struct packed {
        logic irq_en;
        logic halt;
        logic [2:0] ps;
    } pmt_ctrl_t;

endpackage : pmt_pkg

// *** src/pmt_prescaler.sv ***
// Bus clock prescaler giving one-cycle count ticks
`timescale 1ns/1ns
`include "pmt_regs.svh"
module pmt_prescaler
    import pmt_pkg::*;
#(
    parameter int DIV_W = 6
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic run,
    input wire logic clear,
    input wire logic [2:0] sel,
    output logic tick
);

    logic [DIV_W-1:0] div_q;
    logic [2:0] sel_eff;
    logic [DIV_W-1:0] mask;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            div_q <= '0;
        else if (clear)
            div_q <= '0;
        else if (run)
            div_q <= div_q + 1'b1;
    end

    // Code 7 repeats the slowest rate
    assign sel_eff = (sel > `PMT_PS_MAX) ? `PMT_PS_MAX : sel;
    assign mask = DIV_W'((1 << sel_eff) - 1);
    assign tick = run && !clear && ((div_q & mask) == mask);

    chk_tick_phase: assert property (
        @(posedge hclk) disable iff (!hresetn)
        tick && sel_eff != 3'h0 ##1 sel_eff != 3'h0 |-> !tick)
        else $error("prescaler ticked twice in a row");

endmodule : pmt_prescaler

// *** src/pmt_flag_cell.sv ***
// Rollover flag with read-then-write-zero clearing and break protection
`timescale 1ns/1ns
module pmt_flag_cell
    import pmt_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic set,
    input wire logic rd_req,
    input wire logic wr_zero,
    input wire logic block,
    output logic flag_q
);

    logic armed_q;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            armed_q <= 1'b0;
        else if (set)
            armed_q <= 1'b0;
        else if (block)
            armed_q <= armed_q;
        else if (rd_req && flag_q)
            armed_q <= 1'b1;
        else if (wr_zero)
            armed_q <= 1'b0;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            flag_q <= 1'b0;
        else if (set)
            flag_q <= 1'b1;
        else if (wr_zero && armed_q && !block)
            flag_q <= 1'b0;
    end

    chk_flag_protect: assert property (
        @(posedge hclk) disable iff (!hresetn)
        block && flag_q |=> flag_q)
        else $error("flag cleared while protected");

    chk_flag_set_wins: assert property (
        @(posedge hclk) disable iff (!hresetn)
        set |=> flag_q)
        else $error("flag lost a set");

endmodule : pmt_flag_cell

// *** src/pmt_timer.sv ***
// Periodic modulo timer with an AHB-Lite register slave
`timescale 1ns/1ns
`include "pmt_regs.svh"
module pmt_timer
    import pmt_pkg::*;
#(
    parameter int CNT_W = 16,
    parameter int DIV_W = 6
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic wait_mode,
    input wire logic stop_mode,
    input wire logic break_active,
    input wire logic break_clear_enable,
    output logic irq,
    output logic wake_req
);

    pmt_aphase_t aph_q;
    pmt_aphase_t aph_d;
    pmt_ctrl_t ctrl_q;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] mod_q;
    logic [7:0] lat_lo_q;
    logic lat_valid_q;
    logic inhibit_q;
    logic evt_status_q;
    logic evt_enable_q;
    logic [31:0] hrdata_q;
    logic hreadyout_q;
    logic irq_q;
    logic wake_q;

    logic take;
    logic rd_now;
    logic wr_now;
    logic [7:0] wbyte;
    logic [7:0] rbyte;
    logic clr_cnt;
    logic run;
    logic tick;
    logic at_mod;
    logic roll;
    logic flag_set;
    logic flag;
    logic block;
    logic rd_ctrl;
    logic wr_zero;
    logic [7:0] cnt_hi;
    logic [7:0] cnt_lo;
    logic [7:0] mod_hi;
    logic [7:0] mod_lo;

    // Address phase; wait mode shuts the CPU out
    assign take = hsel && hready && htrans[1] && !wait_mode;
    assign wr_now = aph_q.valid && aph_q.write && hreadyout_q;
    assign rd_now = aph_q.valid && !aph_q.write && !hreadyout_q;
    assign wbyte = hwdata[7:0];

    always_comb
    begin
        aph_d.valid = take;
        aph_d.write = hwrite;
        if (haddr[31:10] == 22'h000000 && haddr[1:0] == 2'h0)
            aph_d.idx = haddr[9:2];
        else
            aph_d.idx = `PMT_IDX_NONE;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            aph_q <= '0;
        else if (hreadyout_q)
            aph_q <= aph_d;
        else
            aph_q.valid <= 1'b0;
    end

    // Reads get one wait state so a preceding write is visible
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hreadyout_q <= 1'b1;
        else if (take && !hwrite && hreadyout_q)
            hreadyout_q <= 1'b0;
        else
            hreadyout_q <= 1'b1;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hresp <= 1'b0;
        else
            hresp <= 1'b0;
    end

    assign cnt_hi = cnt_q[CNT_W-1:CNT_W-8];
    assign cnt_lo = cnt_q[7:0];
    assign mod_hi = mod_q[CNT_W-1:CNT_W-8];
    assign mod_lo = mod_q[7:0];

    always_comb
    begin
        rbyte = 8'h00;
        case (aph_q.idx)
            `PMT_IDX_CTRL:
                rbyte = {flag, ctrl_q.irq_en, ctrl_q.halt, 2'h0, ctrl_q.ps};
            `PMT_IDX_CNTH:
                rbyte = cnt_hi;
            `PMT_IDX_CNTL:
                rbyte = lat_valid_q ? lat_lo_q : cnt_lo;
            `PMT_IDX_MODH:
                rbyte = mod_hi;
            `PMT_IDX_MODL:
                rbyte = mod_lo;
            `PMT_IDX_EVT_STATUS:
                rbyte = {7'h00, evt_status_q};
            `PMT_IDX_EVT_ENABLE:
                rbyte = {7'h00, evt_enable_q};
            default:
                rbyte = 8'h00;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata_q <= 32'h00000000;
        else if (rd_now)
            hrdata_q <= {24'h000000, rbyte};
        else
            hrdata_q <= 32'h00000000;
    end

    // High-byte read freezes the low byte until the low byte is read
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            lat_valid_q <= 1'b0;
            lat_lo_q <= 8'h00;
        end
        else if (rd_now && aph_q.idx == `PMT_IDX_CNTH && !lat_valid_q)
        begin
            lat_valid_q <= 1'b1;
            lat_lo_q <= cnt_lo;
        end
        else if (rd_now && aph_q.idx == `PMT_IDX_CNTL)
            lat_valid_q <= 1'b0;
    end

    // Control fields; reset leaves the counter halted
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctrl_q.halt <= `PMT_HALT_RST;
            ctrl_q.irq_en <= `PMT_IRQ_EN_RST;
            ctrl_q.ps <= `PMT_PS_RST;
        end
        else if (wr_now && aph_q.idx == `PMT_IDX_CTRL)
        begin
            ctrl_q.halt <= wbyte[`PMT_BIT_HALT];
            ctrl_q.irq_en <= wbyte[`PMT_BIT_IRQ_EN];
            ctrl_q.ps <= wbyte[`PMT_PS_MSB:0];
        end
    end

    // Counter reset bit acts once and is never stored
    assign clr_cnt = wr_now && aph_q.idx == `PMT_IDX_CTRL
        && wbyte[`PMT_BIT_CRST];

    // Stop and break freeze the prescaler and counter
    assign run = !ctrl_q.halt && !stop_mode && !break_active;

    pmt_prescaler #(
        .DIV_W(DIV_W)
    ) u_prescaler (
        .hclk(hclk),
        .hresetn(hresetn),
        .run(run),
        .clear(clr_cnt),
        .sel(ctrl_q.ps),
        .tick(tick)
    );

    assign at_mod = cnt_q == mod_q;
    assign roll = tick && at_mod;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            cnt_q <= '0;
        else if (clr_cnt)
            cnt_q <= '0;
        else if (roll)
            cnt_q <= '0;
        else if (tick)
            cnt_q <= cnt_q + 1'b1;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            mod_q <= `PMT_MOD_RST;
        else if (wr_now && aph_q.idx == `PMT_IDX_MODH)
            mod_q[CNT_W-1:CNT_W-8] <= wbyte;
        else if (wr_now && aph_q.idx == `PMT_IDX_MODL)
            mod_q[7:0] <= wbyte;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            inhibit_q <= 1'b0;
        else if (wr_now && aph_q.idx == `PMT_IDX_MODH)
            inhibit_q <= 1'b1;
        else if (wr_now && aph_q.idx == `PMT_IDX_MODL)
            inhibit_q <= 1'b0;
    end

    assign flag_set = roll && !inhibit_q;
    assign block = break_active && !break_clear_enable;
    assign rd_ctrl = rd_now && aph_q.idx == `PMT_IDX_CTRL;
    assign wr_zero = wr_now && aph_q.idx == `PMT_IDX_CTRL
        && !wbyte[`PMT_BIT_FLAG];

    pmt_flag_cell u_flag (
        .hclk(hclk),
        .hresetn(hresetn),
        .set(flag_set),
        .rd_req(rd_ctrl),
        .wr_zero(wr_zero),
        .block(block),
        .flag_q(flag)
    );

    // Sticky event copy; a new rollover beats a clear
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            evt_status_q <= 1'b0;
        else if (flag_set)
            evt_status_q <= 1'b1;
        else if (wr_now && aph_q.idx == `PMT_IDX_EVT_CLEAR
            && wbyte[`PMT_EVT_ROLL])
            evt_status_q <= 1'b0;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            evt_enable_q <= 1'b0;
        else if (wr_now && aph_q.idx == `PMT_IDX_EVT_ENABLE)
            evt_enable_q <= wbyte[`PMT_EVT_ROLL];
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            irq_q <= 1'b0;
        else
            irq_q <= (flag && ctrl_q.irq_en)
                || (evt_status_q && evt_enable_q);
    end

    // Wake only matters while the processor waits
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            wake_q <= 1'b0;
        else
            wake_q <= wait_mode && ((flag && ctrl_q.irq_en)
                || (evt_status_q && evt_enable_q));
    end

    assign hrdata = hrdata_q;
    assign hreadyout = hreadyout_q;
    assign irq = irq_q;
    assign wake_req = wake_q;

    chk_cnt_step: assert property (
        @(posedge hclk) disable iff (!hresetn)
        tick && !clr_cnt && !at_mod |=> cnt_q == $past(cnt_q) + 1'b1)
        else $error("counter did not step on tick");

    chk_cnt_idle: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !tick && !clr_cnt |=> cnt_q == $past(cnt_q))
        else $error("counter moved without tick");

    chk_wrap_zero: assert property (
        @(posedge hclk) disable iff (!hresetn)
        tick && at_mod && !clr_cnt |=> cnt_q == '0)
        else $error("counter did not wrap at modulo");

    chk_flag_cause: assert property (
        @(posedge hclk) disable iff (!hresetn)
        $rose(flag) |-> $past(roll) && !$past(inhibit_q))
        else $error("flag rose without rollover");

    chk_inhibit_hold: assert property (
        @(posedge hclk) disable iff (!hresetn)
        inhibit_q |=> !$rose(flag))
        else $error("flag set while modulo update pending");

    chk_irq_gate: assert property (
        @(posedge hclk) disable iff (!hresetn)
        irq_q == ($past(flag && ctrl_q.irq_en)
        || $past(evt_status_q && evt_enable_q)))
        else $error("interrupt without enabled cause");

    chk_break_freeze: assert property (
        @(posedge hclk) disable iff (!hresetn)
        break_active && !clr_cnt |=> $stable(cnt_q))
        else $error("counter ran during break");

    chk_stop_freeze: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (stop_mode || ctrl_q.halt) && !clr_cnt |=> $stable(cnt_q))
        else $error("counter ran while stopped");

    chk_crst_zero: assert property (
        @(posedge hclk) disable iff (!hresetn)
        clr_cnt |=> cnt_q == '0
        ##1 (!$past(ctrl_q.halt) || cnt_q == '0))
        else $error("counter reset bit ignored");

    chk_wait_shut: assert property (
        @(posedge hclk) disable iff (!hresetn)
        wait_mode && hreadyout_q |=> !aph_q.valid)
        else $error("bus access taken in wait mode");

    chk_wake_out: assert property (
        @(posedge hclk) disable iff (!hresetn)
        wait_mode && $stable(wait_mode) && irq_q |-> wake_q)
        else $error("enabled interrupt gave no wake");

endmodule : pmt_timer

// *** verif/periodic_modulo_timer_tb.sv ***
// Self-checking bench of the periodic modulo timer
`timescale 1ns/1ns
`include "pmt_regs.svh"
module periodic_modulo_timer_tb;
    import pmt_pkg::*;
    localparam logic [7:0] R_CT = `PMT_IDX_CTRL;
    localparam logic [7:0] R_MH = `PMT_IDX_MODH;
    localparam logic [7:0] R_ML = `PMT_IDX_MODL;
    localparam logic [7:0] R_ES = `PMT_IDX_EVT_STATUS;
    localparam logic [7:0] R_EC = `PMT_IDX_EVT_CLEAR;
    localparam logic [7:0] R_EE = `PMT_IDX_EVT_ENABLE;
    logic hclk;
    logic hresetn;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    wire logic hready;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic wait_mode;
    logic stop_mode;
    logic break_active;
    logic break_clear_enable;
    logic irq;
    logic wake_req;
    int mismatches;
    int comparisons;
    logic [7:0] m_ctl;
    logic [7:0] m;
    logic [31:0] rd;
    logic [31:0] a;
    logic [31:0] b;
    logic v;
    logic rs;
    assign hready = hreadyout;
    pmt_timer #(.CNT_W(16), .DIV_W(6)) DUT (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .wait_mode(wait_mode),
        .stop_mode(stop_mode), .break_active(break_active),
        .break_clear_enable(break_clear_enable), .irq(irq),
        .wake_req(wake_req));
    initial
    begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end
    task automatic print_verdict();
        $display("Compares %0d, mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // Ready is sampled mid-cycle, where it equals the value at the next edge
    task automatic wait_rdy();
        int n;
        logic r;
        n = 0;
        r = 1'b0;
        while (r !== 1'b1)
        begin
            @(negedge hclk);
            r = hreadyout;
            rd = hrdata;
            rs = hresp;
            @(posedge hclk);
            n++;
            if (n > 50)
            begin
                mismatches++;
                print_verdict();
            end
        end
    endtask : wait_rdy
    task automatic bus(input logic w, input logic [31:0] ad,
                       input logic [7:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= ad;
        wait_rdy();
        htrans <= 2'b00;
        hwdata <= {24'h0, d};
        wait_rdy();
        q = rd;
    endtask : bus
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, {22'h0, i, 2'b00}, d, q);
    endtask : wr
    task automatic rdc(input logic [7:0] i, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, {22'h0, i, 2'b00}, 8'h00, q);
        chk(q, e);
        chk({31'h0, rs}, 32'h0);
    endtask : rdc
    task automatic wr_ctl(input logic [7:0] d);
        wr(R_CT, d);
        m_ctl = d & 8'h67;
    endtask : wr_ctl
    function automatic logic [31:0] ctl(input logic f);
        return {24'h0, f, m_ctl[6:5], 2'b00, m_ctl[2:0]};
    endfunction : ctl
    task automatic rcnt(output logic [31:0] c);
        logic [31:0] h;
        logic [31:0] l;
        bus(1'b0, {22'h0, `PMT_IDX_CNTH, 2'b00}, 8'h00, h);
        bus(1'b0, {22'h0, `PMT_IDX_CNTL, 2'b00}, 8'h00, l);
        c = {16'h0, h[7:0], l[7:0]};
    endtask : rcnt
    // Bounded wait for irq (wk=0) or wake_req (wk=1) to reach a level
    task automatic wait_for(input bit wk, input logic want);
        int n;
        n = 0;
        do
        begin
            @(negedge hclk);
            v = wk ? wake_req : irq;
            @(posedge hclk);
            n++;
        end
        while (v !== want && n < 400);
        chk({31'h0, v}, {31'h0, want});
        if (n >= 400)
            print_verdict();
    endtask : wait_for
    initial
    begin
        {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
        {wait_mode, stop_mode, break_active, break_clear_enable} = '0;
        hsize = 3'h2;
        mismatches = 0;
        comparisons = 0;
        m_ctl = 8'h20;
        a = $urandom(32'h43801338);
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdc(R_CT, ctl(1'b0));
        rdc(R_MH, 32'h0000_00FF);
        rdc(R_ES, 32'h0);
        bus(1'b1, 32'h0000_0400, 8'h55, a);
        bus(1'b0, 32'h0000_0400, 8'h00, a);
        chk(a, 32'h0);
        wr(`PMT_IDX_CNTH, 8'hAA);
        rcnt(a);
        chk(a, 32'h0);
        for (int p = 0; p < 8; p++)
        begin
            wr_ctl(8'h30 | 8'(p));
            rcnt(a);
            chk(a, 32'h0);
            wr_ctl(8'(p));
            repeat (254) @(posedge hclk);
            wr_ctl(8'h20 | 8'(p));
            rcnt(a);
            b = 32'(256 / ((p == 7) ? 64 : (1 << p)));
            chk({31'h0, a + 1 >= b && a <= b + 1}, 32'h1);
            rcnt(b);
            chk(b, a);
        end
        m = 8'($urandom_range(9, 2));
        wr_ctl(8'h30);
        wr(R_MH, 8'h00);
        wr(R_ML, m);
        rdc(R_ML, {24'h0, m});
        wr_ctl(8'h00);
        repeat (40) @(posedge hclk);
        wait_for(1'b0, 1'b0);
        rdc(R_CT, ctl(1'b1));
        for (int k = 0; k < 6; k++)
        begin
            rcnt(a);
            chk({31'h0, a <= {24'h0, m}}, 32'h1);
        end
        wr_ctl(8'h40);
        wait_for(1'b0, 1'b1);
        rdc(R_ES, 32'h1);
        wr_ctl(8'h60);
        wr_ctl(8'h60);
        rdc(R_CT, ctl(1'b1));
        wr_ctl(8'hE0);
        rdc(R_CT, ctl(1'b1));
        wr_ctl(8'h60);
        rdc(R_CT, ctl(1'b0));
        wait_for(1'b0, 1'b0);
        wr_ctl(8'h40);
        wait_for(1'b0, 1'b1);
        rdc(R_CT, ctl(1'b1));
        repeat (20) @(posedge hclk);
        wr_ctl(8'h40);
        wr_ctl(8'h60);
        rdc(R_CT, ctl(1'b1));
        wr_ctl(8'h20);
        rdc(R_CT, ctl(1'b0));
        wr(R_EE, 8'h01);
        wait_for(1'b0, 1'b1);
        wr(R_EE, 8'h00);
        wait_for(1'b0, 1'b0);
        wr(R_EC, 8'h01);
        rdc(R_ES, 32'h0);
        wr_ctl(8'h30);
        wr(R_MH, 8'h00);
        wr_ctl(8'h00);
        repeat (40) @(posedge hclk);
        wr_ctl(8'h20);
        rdc(R_CT, ctl(1'b0));
        wr(R_ML, m);
        wr_ctl(8'h40);
        wait_for(1'b0, 1'b1);
        break_active <= 1'b1;
        rcnt(a);
        repeat ($urandom_range(30, 5)) @(posedge hclk);
        rcnt(b);
        chk(b, a);
        rdc(R_CT, ctl(1'b1));
        wr_ctl(8'h60);
        rdc(R_CT, ctl(1'b1));
        break_active <= 1'b0;
        wr_ctl(8'h60);
        rdc(R_CT, ctl(1'b1));
        break_active <= 1'b1;
        wr_ctl(8'h60);
        rdc(R_CT, ctl(1'b1));
        break_active <= 1'b0;
        wr_ctl(8'h60);
        rdc(R_CT, ctl(1'b0));
        wr_ctl(8'h40);
        wait_for(1'b0, 1'b1);
        wr_ctl(8'h60);
        break_clear_enable <= 1'b1;
        break_active <= 1'b1;
        rdc(R_CT, ctl(1'b1));
        wr_ctl(8'h60);
        rdc(R_CT, ctl(1'b0));
        break_active <= 1'b0;
        break_clear_enable <= 1'b0;
        rdc(R_CT, ctl(1'b0));
        wr_ctl(8'h33);
        wr(R_MH, 8'h12);
        wr(R_ML, 8'h34);
        wr_ctl(8'h03);
        stop_mode <= 1'b1;
        rcnt(a);
        repeat (30) @(posedge hclk);
        rcnt(b);
        chk(b, a);
        rdc(R_CT, ctl(1'b0));
        rdc(R_MH, 32'h0000_0012);
        stop_mode <= 1'b0;
        wait_mode <= 1'b1;
        rcnt(a);
        chk(a, 32'h0);
        wr(R_CT, 8'h20);
        wait_mode <= 1'b0;
        rcnt(a);
        repeat (50) @(posedge hclk);
        rcnt(b);
        chk({31'h0, b > a}, 32'h1);
        rcnt(a);
        wait_mode <= 1'b1;
        repeat (40) @(posedge hclk);
        wait_mode <= 1'b0;
        rcnt(b);
        chk({31'h0, b > a}, 32'h1);
        wr_ctl(8'h30);
        wr(R_MH, 8'h00);
        wr(R_ML, m);
        wr_ctl(8'h40);
        wait_for(1'b0, 1'b1);
        wait_for(1'b1, 1'b0);
        wait_mode <= 1'b1;
        wait_for(1'b1, 1'b1);
        wait_mode <= 1'b0;
        wait_for(1'b1, 1'b0);
        wr_ctl(8'h60);
        rcnt(a);
        wait_mode <= 1'b1;
        repeat (30) @(posedge hclk);
        wait_mode <= 1'b0;
        rcnt(b);
        chk(b, a);
        print_verdict();
    end
endmodule : periodic_modulo_timer_tb
